// ---- bench/ahb_far_model.sv ----
module ahb_far_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [matrix_arb_pkg::NUM_SLAVES-1:0] stall,
   output logic [matrix_arb_pkg::NUM_SLAVES-1:0] s_hready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slaves finish each beat at once unless the bench asks for wait states
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_hready <= '1;
      end else begin
         s_hready <= ~stall;
      end
   end
endmodule

// ---- bench/test_ahb_slave_arbiter_default_master.sv ----
module test_ahb_slave_arbiter_default_master;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [8:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   matrix_arb_pkg::m_bus_t [matrix_arb_pkg::NUM_MASTERS-1:0] m_bus;
   logic [matrix_arb_pkg::NUM_SLAVES-1:0] s_hready, stall;
   matrix_arb_pkg::s_grant_t [matrix_arb_pkg::NUM_SLAVES-1:0] s_grant;
   logic [matrix_arb_pkg::NUM_MASTERS-1:0] m_granted;
   int fails, comparisons, a, b, la, lb, fm;

   matrix_slave_arbiter u_matrix_slave_arbiter (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .m_bus(m_bus), .s_hready(s_hready), .s_grant(s_grant), .m_granted(m_granted));
   ahb_far_model u_ahb_far_model (.mclk(mclk), .rst_n(rst_n), .stall(stall),
      .s_hready(s_hready));

   // Free-running system clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic test_done();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) begin
         fails++;
         test_done();
      end
   endtask

   // One master address phase, always a single transfer
   task automatic drv(input int m, input int r, input logic [1:0] t);
      m_bus[m] <= '{region: 4'(r), htrans: t, hburst: matrix_arb_pkg::HBURST_SINGLE};
   endtask

   task automatic edge_n(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic gchk(input int s, input int m);
      check(32'(s_grant[s]), {27'h0, 1'b1, 4'(m)});
      check(32'(m_granted[m]), 32'h1);
   endtask

   // Reference decoder: remap moves region 0 onto slave 1
   function automatic int dec(input int region, input bit remap);
      if (region == 0 && remap) return 1;
      return region;
   endfunction

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 9'h000;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      m_bus = '0;
      stall = '0;
      fails = 0;
      comparisons = 0;
      void'($urandom(56));
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      // Values after reset; prediction stays at its default setting
      wb(1'b0, 9'h000, 32'h0);
      check(rd, matrix_arb_pkg::MCFG0_RST);
      wb(1'b0, 9'h004, 32'h0);
      check(rd, matrix_arb_pkg::MCFG_RST);
      wb(1'b0, 9'h040, 32'h0);
      check(rd, matrix_arb_pkg::SCFG_RST);
      wb(1'b0, 9'h1F0, 32'h0);
      check(rd, 32'h0);
      // Reserved type 3 with every writable bit set
      wb(1'b1, 9'h048, 32'hFFFFFFFF);
      wb(1'b0, 9'h048, 32'h0);
      check(rd, matrix_arb_pkg::SCFG_MASK);
      // Stalled single access keeps the slave; a second request waits
      // Slot limit stays enabled at its maximum while masters contend
      @(posedge mclk);
      stall[2] <= 1'b1;
      drv(3, 2, matrix_arb_pkg::HTRANS_NONSEQ);
      #1;
      check(32'(s_grant[2].conn), 32'h0);
      @(posedge mclk);
      drv(5, 2, matrix_arb_pkg::HTRANS_NONSEQ);
      #1;
      gchk(2, 3);
      for (int i = 0; i < 6; i++) begin
         edge_n(1);
         gchk(2, 3);
      end
      @(posedge mclk);
      stall[2] <= 1'b0;
      drv(3, 2, matrix_arb_pkg::HTRANS_IDLE);
      edge_n(2);
      gchk(2, 5);
      drv(5, 2, matrix_arb_pkg::HTRANS_IDLE);
      edge_n(3);
      check(32'(s_grant[2].conn), 32'h0);
      check(32'(m_granted), 32'h0);
      // Last access master parking
      wb(1'b1, 9'h048, 32'h000101FF);
      @(posedge mclk);
      drv(7, 2, matrix_arb_pkg::HTRANS_NONSEQ);
      @(posedge mclk);
      drv(7, 2, matrix_arb_pkg::HTRANS_IDLE);
      edge_n(3);
      gchk(2, 7);
      drv(9, 2, matrix_arb_pkg::HTRANS_NONSEQ);
      #1;
      gchk(2, 7);
      edge_n(1);
      gchk(2, 9);
      drv(9, 2, matrix_arb_pkg::HTRANS_IDLE);
      edge_n(3);
      gchk(2, 9);
      // Fixed default master, random number
      fm = $urandom_range(11, 0);
      wb(1'b1, 9'h048, 32'h000201FF | (32'(fm) << 18));
      edge_n(3);
      gchk(2, fm);
      drv(fm, 2, matrix_arb_pkg::HTRANS_NONSEQ);
      #1;
      gchk(2, fm);
      @(posedge mclk);
      drv(fm, 2, matrix_arb_pkg::HTRANS_IDLE);
      // Remap of master 4 only
      wb(1'b1, 9'h100, 32'h00000010);
      @(posedge mclk);
      drv(4, 0, matrix_arb_pkg::HTRANS_NONSEQ);
      drv(6, 0, matrix_arb_pkg::HTRANS_NONSEQ);
      edge_n(1);
      gchk(dec(0, 1'b1), 4);
      gchk(dec(0, 1'b0), 6);
      drv(4, 0, matrix_arb_pkg::HTRANS_IDLE);
      drv(6, 0, matrix_arb_pkg::HTRANS_IDLE);
      // Pure fixed priority on slave 6 between two random masters
      a = $urandom_range(7, 0);
      b = (a + 1 + $urandom_range(6, 0)) % 8;
      la = $urandom_range(3, 0);
      lb = (la + 1 + $urandom_range(2, 0)) % 4;
      wb(1'b1, 9'h0B0, (32'(la) << (4 * a)) | (32'(lb) << (4 * b)));
      wb(1'b1, 9'h058, 32'h010001FF);
      @(posedge mclk);
      drv(a, 6, matrix_arb_pkg::HTRANS_NONSEQ);
      drv(b, 6, matrix_arb_pkg::HTRANS_NONSEQ);
      edge_n(1);
      gchk(6, (la > lb) ? a : b);
      test_done();
   end
endmodule

// ---- rtl/matrix_arb_pkg.sv ----
package matrix_arb_pkg;

   // Matrix dimensions
   localparam int NUM_MASTERS = 12;
   localparam int NUM_SLAVES = 8;

   // AHB transfer and burst codes
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HBURST_SINGLE = 3'h0;
   localparam logic [2:0] HBURST_INCR = 3'h1;

   // Default master types, value 3 reserved and handled as none
   localparam logic [1:0] DEF_NONE = 2'h0;
   localparam logic [1:0] DEF_LAST = 2'h1;
   localparam logic [1:0] DEF_FIXED = 2'h2;

   // Register byte offsets
   localparam logic [8:0] MCFG_BASE = 9'h000;
   localparam logic [8:0] MCFG_END = 9'h02C;
   localparam logic [8:0] SCFG_BASE = 9'h040;
   localparam logic [8:0] SCFG_END = 9'h05C;
   localparam logic [8:0] PRIO_BASE = 9'h080;
   localparam logic [8:0] PRIO_END = 9'h0BC;
   localparam logic [8:0] REMAP_OFF = 9'h100;
   localparam logic [8:0] STATUS_BASE = 9'h120;
   localparam logic [8:0] STATUS_END = 9'h13C;

   // Field positions and writable masks
   localparam int SCFG_SLOT_LSB = 0;
   localparam int SCFG_DEFTYPE_LSB = 16;
   localparam int SCFG_FIXED_LSB = 18;
   localparam int SCFG_ARBFIX_BIT = 24;
   localparam int PRIO_FIELD_STRIDE = 4;
   localparam int PRIO_MASTERS_PER_REG = 8;
   localparam logic [31:0] MCFG_MASK = 32'h00000007;
   localparam logic [31:0] SCFG_MASK = 32'h013F01FF;
   localparam logic [31:0] PRA_MASK = 32'h33333333;
   localparam logic [31:0] PRB_MASK = 32'h00003333;
   localparam logic [31:0] REMAP_MASK = 32'h00000FFF;

   // Values after reset
   localparam logic [31:0] MCFG0_RST = 32'h00000001;
   localparam logic [31:0] MCFG_RST = 32'h00000000;
   localparam logic [31:0] SCFG_RST = 32'h000001FF;
   localparam logic [31:0] PRIO_RST = 32'h00000000;
   localparam logic [31:0] REMAP_RST = 32'h00000000;

   // Address decoding: region selects a slave, remap moves region 0
   localparam logic [3:0] REMAP_REGION = 4'h0;
   localparam logic [2:0] REMAP_SLAVE = 3'h1;

   // Per-slave connection state
   typedef enum logic [2:0] {
      S_OFF = 3'b001,
      S_PARK = 3'b010,
      S_XFER = 3'b100
   } slave_state_t;

   // Request side of one master port
   typedef struct packed {
      logic [3:0] region;
      logic [1:0] htrans;
      logic [2:0] hburst;
   } m_bus_t;

   // Grant presented to one slave port
   typedef struct packed {
      logic conn;
      logic [3:0] master;
   } s_grant_t;

endpackage

// ---- rtl/matrix_slave_arbiter.sv ----
// Decided for this implementation: the Wishbone register port and the address map.
module matrix_slave_arbiter (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire matrix_arb_pkg::m_bus_t [matrix_arb_pkg::NUM_MASTERS-1:0] m_bus,
   input wire logic [matrix_arb_pkg::NUM_SLAVES-1:0] s_hready,
   output matrix_arb_pkg::s_grant_t [matrix_arb_pkg::NUM_SLAVES-1:0] s_grant,
   output logic [matrix_arb_pkg::NUM_MASTERS-1:0] m_granted
);

   localparam int NM = matrix_arb_pkg::NUM_MASTERS;
   localparam int NS = matrix_arb_pkg::NUM_SLAVES;

   logic [31:0] master_config_reg [NM];
   logic [31:0] slave_config_reg [NS];
   logic [31:0] prio_a [NS];
   logic [31:0] prio_b [NS];
   logic [31:0] master_remap_control;
   logic [7:0] beat_cnt [NS];
   logic [8:0] slot_cnt [NS];
   matrix_arb_pkg::slave_state_t slave_state [NS];
   logic [3:0] decode [NM];
   logic [NM-1:0] req_vec [NS];
   logic [2*NM-1:0] prio_vec [NS];
   logic owner_act [NS];
   logic last_beat [NS];
   logic arb_ok [NS];
   logic grant_new [NS];
   logic [31:0] rd_data;
   matrix_arb_pkg::s_grant_t [NS-1:0] next_grant;
   matrix_arb_pkg::slave_state_t next_state [NS];
   logic [NM-1:0] next_granted;
   logic wb_req;

   // Byte-lane merge of a register write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b+:8] = wd[8*b+:8];
         end
      end
      return res & mask;
   endfunction

   // Predicted INCR length, zero means no prediction
   function automatic logic [8:0] predict_len(input logic [2:0] code);
      case (code)
         3'h0: predict_len = 9'h000;
         3'h1: predict_len = 9'h001;
         3'h2: predict_len = 9'h004;
         3'h3: predict_len = 9'h008;
         3'h4: predict_len = 9'h010;
         3'h5: predict_len = 9'h020;
         3'h6: predict_len = 9'h040;
         default: predict_len = 9'h080;
      endcase
   endfunction

   // Beats per burst, defined lengths or the master's INCR setting
   function automatic logic [8:0] burst_len(input logic [2:0] hburst,
                                            input logic [2:0] incr_code);
      case (hburst)
         matrix_arb_pkg::HBURST_SINGLE: burst_len = 9'h001;
         matrix_arb_pkg::HBURST_INCR: burst_len = predict_len(incr_code);
         3'h2, 3'h3: burst_len = 9'h004;
         3'h4, 3'h5: burst_len = 9'h008;
         default: burst_len = 9'h010;
      endcase
   endfunction

   // Region to slave, with per-master remap of region zero
   function automatic logic [3:0] dec(input logic [3:0] region, input logic remap);
      if (remap && region == matrix_arb_pkg::REMAP_REGION) begin
         dec = {1'b1, matrix_arb_pkg::REMAP_SLAVE};
      end else begin
         dec = {!region[3], region[2:0]};
      end
   endfunction

   // Winner among candidates: top level first, then rotation or number
   function automatic logic [4:0] pick(input logic [NM-1:0] cand, input logic [2*NM-1:0] pv,
                                       input logic [3:0] last, input logic fixed_only);
      logic [1:0] top;
      logic [NM-1:0] pool;
      logic found;
      logic [3:0] win;
      int idx;
      top = 2'h0;
      pool = '0;
      found = 1'b0;
      win = 4'h0;
      idx = 0;
      for (int m = 0; m < NM; m++) begin
         if (cand[m] && pv[2*m+:2] > top) begin
            top = pv[2*m+:2];
         end
      end
      for (int m = 0; m < NM; m++) begin
         pool[m] = cand[m] && pv[2*m+:2] == top;
      end
      if (!fixed_only && (top == 2'h0 || top == 2'h3)) begin
         for (int k = 1; k <= NM; k++) begin
            idx = (int'(last) + k) % NM;
            if (pool[idx] && !found) begin
               found = 1'b1;
               win = 4'(idx);
            end
         end
      end else begin
         for (int m = NM - 1; m >= 0; m--) begin
            if (pool[m] && !found) begin
               found = 1'b1;
               win = 4'(m);
            end
         end
      end
      return {found, win};
   endfunction

   // One decoder per master port
   always_comb begin
      for (int m = 0; m < NM; m++) begin
         decode[m] = dec(m_bus[m].region, master_remap_control[m]);
      end
   end

   // Per-slave arbiter: requests, arbitration points, next owner
   always_comb begin
      logic [3:0] own;
      logic [NM-1:0] cand;
      logic [4:0] win;
      logic [8:0] blen;
      logic [7:0] cur;
      logic [7:0] mask;
      logic [1:0] dtype;
      logic [31:0] scfg;
      own = 4'h0;
      cand = '0;
      win = 5'h00;
      blen = 9'h000;
      cur = 8'h00;
      mask = 8'h00;
      dtype = 2'h0;
      scfg = 32'h0;
      next_granted = '0;
      for (int s = 0; s < NS; s++) begin
         scfg = slave_config_reg[s];
         own = s_grant[s].master;
         for (int m = 0; m < NM; m++) begin
            req_vec[s][m] = m_bus[m].htrans[1] && decode[m] == {1'b1, 3'(s)};
            prio_vec[s][2*m+:2] = (m < matrix_arb_pkg::PRIO_MASTERS_PER_REG) ?
               prio_a[s][matrix_arb_pkg::PRIO_FIELD_STRIDE*m+:2] :
               prio_b[s][matrix_arb_pkg::PRIO_FIELD_STRIDE*(m-8)+:2];
         end
         owner_act[s] = s_grant[s].conn && m_bus[own].htrans != matrix_arb_pkg::HTRANS_IDLE &&
                        decode[own] == {1'b1, 3'(s)};
         blen = burst_len(m_bus[own].hburst, master_config_reg[own][2:0]);
         cur = (m_bus[own].htrans == matrix_arb_pkg::HTRANS_NONSEQ) ? 8'h00 : beat_cnt[s];
         mask = 8'(blen - 9'h001);
         last_beat[s] = owner_act[s] && m_bus[own].htrans[1] && s_hready[s] &&
                        blen != 9'h000 && (cur & mask) == mask;
         // Slot expiry only acts when the running beat completes
         arb_ok[s] = !owner_act[s] || last_beat[s] ||
                     (scfg[8:0] != 9'h000 && slot_cnt[s] == 9'h000 && s_hready[s]);
         cand = req_vec[s];
         if (s_grant[s].conn && (cand & ~(NM'(1) << own)) != '0) begin
            cand = cand & ~(NM'(1) << own);
         end
         win = pick(cand, prio_vec[s], own, scfg[matrix_arb_pkg::SCFG_ARBFIX_BIT]);
         dtype = scfg[matrix_arb_pkg::SCFG_DEFTYPE_LSB+:2];
         next_grant[s] = s_grant[s];
         grant_new[s] = 1'b0;
         if (arb_ok[s] && win[4]) begin
            next_grant[s] = '{conn: 1'b1, master: win[3:0]};
            grant_new[s] = 1'b1;
         end else if (arb_ok[s]) begin
            case (dtype)
               matrix_arb_pkg::DEF_LAST: next_grant[s] = s_grant[s];
               matrix_arb_pkg::DEF_FIXED: begin
                  next_grant[s] = '{conn: 1'b1,
                     master: scfg[matrix_arb_pkg::SCFG_FIXED_LSB+:4]};
               end
               default: next_grant[s] = '{conn: 1'b0, master: own};
            endcase
         end
         case (slave_state[s])
            matrix_arb_pkg::S_XFER: begin
               next_state[s] = !next_grant[s].conn ? matrix_arb_pkg::S_OFF :
                  (arb_ok[s] ? matrix_arb_pkg::S_PARK : matrix_arb_pkg::S_XFER);
            end
            matrix_arb_pkg::S_OFF, matrix_arb_pkg::S_PARK: begin
               next_state[s] = !next_grant[s].conn ? matrix_arb_pkg::S_OFF :
                  (req_vec[s][next_grant[s].master] ? matrix_arb_pkg::S_XFER :
                   matrix_arb_pkg::S_PARK);
            end
            default: next_state[s] = matrix_arb_pkg::S_OFF;
         endcase
         if (next_grant[s].conn) begin
            next_granted[next_grant[s].master] = 1'b1;
         end
      end
   end

   // Grant registers; a parked owner keeps the path with no gap
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_grant <= '0;
         m_granted <= '0;
         for (int s = 0; s < NS; s++) begin
            slave_state[s] <= matrix_arb_pkg::S_OFF;
         end
      end else if (ce) begin
         s_grant <= next_grant;
         m_granted <= next_granted;
         for (int s = 0; s < NS; s++) begin
            slave_state[s] <= next_state[s];
         end
      end
   end

   // Beat position inside the owner's burst
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < NS; s++) begin
            beat_cnt[s] <= 8'h00;
         end
      end else if (ce) begin
         for (int s = 0; s < NS; s++) begin
            if (owner_act[s] && s_hready[s] && m_bus[s_grant[s].master].htrans[1]) begin
               beat_cnt[s] <= (m_bus[s_grant[s].master].htrans == matrix_arb_pkg::HTRANS_NONSEQ)
                               ? 8'h01 : beat_cnt[s] + 8'h01;
            end
         end
      end
   end

   // Slot counter: load at each grant, then count down to zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < NS; s++) begin
            slot_cnt[s] <= 9'h000;
         end
      end else if (ce) begin
         for (int s = 0; s < NS; s++) begin
            if (grant_new[s]) begin
               slot_cnt[s] <= slave_config_reg[s][matrix_arb_pkg::SCFG_SLOT_LSB+:9];
            end else if (slot_cnt[s] != 9'h000) begin
               slot_cnt[s] <= slot_cnt[s] - 9'h001;
            end
         end
      end
   end

   // Register read mux
   always_comb begin
      rd_data = 32'h0;
      if (wb_adr_i <= matrix_arb_pkg::MCFG_END) begin
         rd_data = master_config_reg[wb_adr_i[5:2]];
      end else if (wb_adr_i >= matrix_arb_pkg::SCFG_BASE && wb_adr_i <= matrix_arb_pkg::SCFG_END) begin
         rd_data = slave_config_reg[wb_adr_i[4:2]];
      end else if (wb_adr_i >= matrix_arb_pkg::PRIO_BASE && wb_adr_i <= matrix_arb_pkg::PRIO_END) begin
         rd_data = wb_adr_i[2] ? prio_b[wb_adr_i[5:3]] : prio_a[wb_adr_i[5:3]];
      end else if (wb_adr_i[8:2] == matrix_arb_pkg::REMAP_OFF[8:2]) begin
         rd_data = master_remap_control;
      end else if (wb_adr_i >= matrix_arb_pkg::STATUS_BASE && wb_adr_i <= matrix_arb_pkg::STATUS_END) begin
         rd_data = {16'h0, slot_cnt[wb_adr_i[4:2]][7:0], slave_state[wb_adr_i[4:2]],
                    s_grant[wb_adr_i[4:2]]};
      end
   end

   assign wb_req = wb_cyc_i && wb_stb_i;

   // Wishbone slave: ack one cycle after the request, data latched with it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce) begin
         wb_ack_o <= wb_req && !wb_ack_o;
         if (wb_req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // Register writes at the edge the master sees ack
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int m = 0; m < NM; m++) begin
            master_config_reg[m] <= (m == 0) ? matrix_arb_pkg::MCFG0_RST : matrix_arb_pkg::MCFG_RST;
         end
         for (int s = 0; s < NS; s++) begin
            slave_config_reg[s] <= matrix_arb_pkg::SCFG_RST;
            prio_a[s] <= matrix_arb_pkg::PRIO_RST;
            prio_b[s] <= matrix_arb_pkg::PRIO_RST;
         end
         master_remap_control <= matrix_arb_pkg::REMAP_RST;
      end else if (ce && wb_req && wb_ack_o && wb_we_i) begin
         if (wb_adr_i <= matrix_arb_pkg::MCFG_END) begin
            master_config_reg[wb_adr_i[5:2]] <= merge(master_config_reg[wb_adr_i[5:2]],
               wb_dat_i, wb_sel_i, matrix_arb_pkg::MCFG_MASK);
         end else if (wb_adr_i >= matrix_arb_pkg::SCFG_BASE &&
                      wb_adr_i <= matrix_arb_pkg::SCFG_END) begin
            slave_config_reg[wb_adr_i[4:2]] <= merge(slave_config_reg[wb_adr_i[4:2]],
               wb_dat_i, wb_sel_i, matrix_arb_pkg::SCFG_MASK);
         end else if (wb_adr_i >= matrix_arb_pkg::PRIO_BASE &&
                      wb_adr_i <= matrix_arb_pkg::PRIO_END) begin
            if (wb_adr_i[2]) begin
               prio_b[wb_adr_i[5:3]] <= merge(prio_b[wb_adr_i[5:3]], wb_dat_i, wb_sel_i,
                                              matrix_arb_pkg::PRB_MASK);
            end else begin
               prio_a[wb_adr_i[5:3]] <= merge(prio_a[wb_adr_i[5:3]], wb_dat_i, wb_sel_i,
                                              matrix_arb_pkg::PRA_MASK);
            end
         end else if (wb_adr_i[8:2] == matrix_arb_pkg::REMAP_OFF[8:2]) begin
            master_remap_control <= merge(master_remap_control, wb_dat_i, wb_sel_i,
                                          matrix_arb_pkg::REMAP_MASK);
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Bus answer timing
   a_wb_ack_timing: assert property (ce && wb_req && !wb_ack_o |=> wb_ack_o)
      else $error("wishbone ack missing after request");
   a_wb_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
      else $error("wishbone ack held for two cycles");

   for (genvar g = 0; g < NS; g++) begin : g_chk
      sequence s_quiet_point;
         ce && arb_ok[g] && !(|req_vec[g]);
      endsequence
      sequence s_contended;
         ce && arb_ok[g] && s_grant[g].conn &&
            ((req_vec[g] & ~(NM'(1) << s_grant[g].master)) != '0);
      endsequence
      a_none_release: assert property (s_quiet_point and
         ##0 slave_config_reg[g][17:16] == matrix_arb_pkg::DEF_NONE |=> !s_grant[g].conn)
         else $error("slave not released without default master");
      a_fixed_park: assert property (s_quiet_point and
         ##0 slave_config_reg[g][17:16] == matrix_arb_pkg::DEF_FIXED
         |=> s_grant[g].conn && s_grant[g].master == $past(slave_config_reg[g][21:18]))
         else $error("slave not parked on fixed master");
      a_last_park: assert property (s_quiet_point and
         ##0 slave_config_reg[g][17:16] == matrix_arb_pkg::DEF_LAST
         |=> s_grant[g] == $past(s_grant[g]))
         else $error("last access master not kept");
      a_burst_hold: assert property (ce && !arb_ok[g] |=> s_grant[g] == $past(s_grant[g]))
         else $error("grant changed inside an access");
      a_no_repeat: assert property (s_contended |=>
         s_grant[g].conn && s_grant[g].master != $past(s_grant[g].master))
         else $error("owner granted twice while others wait");
      a_slot_load: assert property (ce && grant_new[g] |=> slot_cnt[g] == $past(slave_config_reg[g][8:0]))
         else $error("slot counter not loaded at grant");
      a_slot_count: assert property (ce && !grant_new[g] && slot_cnt[g] != 9'h000
         |=> slot_cnt[g] == $past(slot_cnt[g]) - 9'h001)
         else $error("slot counter did not decrement");
   end

endmodule
